// *** logic/smx_consts.svh ***
// Purpose: constants for the special microcommand execution block
// Assumes: 16-bit data path, one clock, wishbone register access
// Notes:   Summary of operation follows
//
// Summary of operation
// - divide step: conditional subtract, carry into link
// - divide repeats on loop counter, exits at zero
// - carry mode forces carry in, updates link
// - next-control field inhibit code stops next command on divide exit or bit-test hit
// - a operand and extension shift left, link in
// - bit-test branches to target on a hit, skip ignored
// - bit-test passes a operand unchanged
// - test sense picks one or zero match
// - branch on bit test or condition test
// - condition codes zero..odd, code seven never
// - special commands other than divide copy a operand to bus
// - status update passes a, loads low status
// - emulate table gives per-bit status functions
// - micro status source moves flags into status
// - low four status bits update in one step
// - a conditional access picks restore or rmw
// - address from a operand, word or byte
// - read data loaded into return register
// - conditional access beats function field access
// - b conditional access uses b operand
`ifndef SMX_CONSTS_SVH
`define SMX_CONSTS_SVH
`define SMX_OP_DIV      5'h1a
`define SMX_OP_BTB      5'h1b
`define SMX_OP_STU      5'h1c
`define SMX_OP_CMA      5'h1d
`define SMX_OP_CMB      5'h1e
`define SMX_MC_DIV      4'h5
`define SMX_NX_INHIBIT  2'h3
`define SMX_SB_NEVER    3'h7
`define SMX_LC_RESET    4'hf
`define SMX_ADR_STATUS  8'h00
`define SMX_ADR_XR      8'h04
`define SMX_ADR_RR      8'h08
`define SMX_ADR_LC      8'h0c
`define SMX_ADR_ET_LO   8'h40
`define SMX_ADR_ET_HI   8'h7c
`define SMX_ET_RMW      8
`define SMX_ET_BYTE     9
`endif

// *** logic/smx_pkg.sv ***
// Purpose: shared types for the special microcommand block
// Assumes: nothing
// Notes:   per-bit macro status update function codes
package smx_pkg;
    typedef enum logic [1:0] {
        SMX_UPD_KEEP  = 2'b00,
        SMX_UPD_CLEAR = 2'b01,
        SMX_UPD_SET   = 2'b10,
        SMX_UPD_LOAD  = 2'b11
    } smx_upd_t;
endpackage

// *** logic/smx_exec.sv ***
// Purpose: execute divide step, bit-test branch, status update and
//          conditional memory access microcommands
// Assumes: sequencer presents one command per cmd_valid pulse
// Notes:   emulate table is written over wishbone, indexed by instr[15:12]
//
// The register addresses and register access over Wishbone are this design's own decisions.
`include "smx_consts.svh"
module smx_exec #(
    parameter int W = 16
) (
    // clock and reset
    input  wire logic          clk,
    input  wire logic          arst_n,
    // wishbone slave
    input  wire logic          wb_cyc_i,
    input  wire logic          wb_stb_i,
    input  wire logic          wb_we_i,
    input  wire logic [7:0]    wb_adr_i,
    input  wire logic [3:0]    wb_sel_i,
    input  wire logic [31:0]   wb_dat_i,
    output logic      [31:0]   wb_dat_o,
    output logic               wb_ack_o,
    // microcommand from sequencer
    input  wire logic          cmd_valid,
    input  wire logic [4:0]    command_code_field,
    input  wire logic [2:0]    branch_cond_field,
    input  wire logic          skip_select,
    input  wire logic          test_sense,
    input  wire logic [3:0]    bit_select,
    input  wire logic [3:0]    carry_mode_field,
    input  wire logic [1:0]    next_ctrl_field,
    input  wire logic [9:0]    branch_target_field,
    input  wire logic          a_src_is_ms,
    input  wire logic          fn_mem_req,
    input  wire logic          dl_shift,
    input  wire logic          lc_load,
    input  wire logic [3:0]    lc_value,
    input  wire logic          xr_load,
    input  wire logic [W-1:0]  xr_value,
    input  wire logic          link_clear,
    // operands and flags
    input  wire logic [W-1:0]  a_operand_path,
    input  wire logic [W-1:0]  b_operand_path,
    input  wire logic [15:0]   emulated_instr_hold,
    input  wire logic          flag_carry,
    input  wire logic          flag_overflow,
    input  wire logic          flag_zero,
    input  wire logic          flag_negative,
    input  wire logic          flag_positive,
    input  wire logic          flag_odd,
    input  wire logic [3:0]    micro_status_reg,
    // results to sequencer
    output logic [W-1:0]       dest_data,
    output logic               dest_we,
    output logic [W-1:0]       main_bus_path,
    output logic               branch_take,
    output logic [9:0]         branch_addr,
    output logic               inhibit_next,
    output logic               fn_mem_go,
    // memory access
    output logic               mem_req,
    output logic               mem_rmw,
    output logic               mem_byte,
    output logic [W-1:0]       mem_addr,
    output logic [W-1:0]       mem_wdata,
    input  wire logic          mem_ack,
    input  wire logic [W-1:0]  mem_rdata,
    // state view
    output logic [15:0]        macro_status,
    output logic [W-1:0]       extension_reg,
    output logic [W-1:0]       read_return_reg,
    output logic [3:0]         loop_counter,
    output logic               link
);
    logic [9:0]  emu_table [16];

    function automatic logic upd_bit(logic [1:0] f, logic old,
                                     logic nv);
        unique case (smx_pkg::smx_upd_t'(f))
            smx_pkg::SMX_UPD_KEEP:  upd_bit = old;
            smx_pkg::SMX_UPD_CLEAR: upd_bit = 1'b0;
            smx_pkg::SMX_UPD_SET:   upd_bit = 1'b1;
            smx_pkg::SMX_UPD_LOAD:  upd_bit = nv;
        endcase
    endfunction

    // command decode
    wire is_div = cmd_valid && command_code_field == `SMX_OP_DIV;
    wire is_btb = cmd_valid && command_code_field == `SMX_OP_BTB;
    wire is_stu = cmd_valid && command_code_field == `SMX_OP_STU;
    wire is_cma = cmd_valid && command_code_field == `SMX_OP_CMA;
    wire is_cmb = cmd_valid && command_code_field == `SMX_OP_CMB;
    wire is_acc = is_cma || is_cmb;
    wire [9:0] emu_entry = emu_table[emulated_instr_hold[15:12]];

    // divide step
    wire           cin_one = carry_mode_field == `SMX_MC_DIV;
    wire [W:0]     div_sum = {1'b0, a_operand_path}
                           + {1'b0, ~b_operand_path}
                           + {{W{1'b0}}, cin_one};
    wire           div_carry = div_sum[W];
    wire [W-1:0]   div_res = div_carry ? div_sum[W-1:0]
                                       : a_operand_path;
    wire           lc_zero = loop_counter == 4'h0;

    // bit-test branch
    wire       tst_bit = a_operand_path[bit_select];
    logic      sb_cond;
    always_comb begin
        unique case (branch_cond_field)
            3'h0:    sb_cond = lc_zero;
            3'h1:    sb_cond = flag_carry;
            3'h2:    sb_cond = flag_overflow;
            3'h3:    sb_cond = flag_zero;
            3'h4:    sb_cond = flag_negative;
            3'h5:    sb_cond = flag_positive;
            3'h6:    sb_cond = flag_odd;
            3'h7:    sb_cond = 1'b0;
        endcase
    end
    // skip_select deliberately unused: this command branches, never skips
    wire btb_hit = (tst_bit == test_sense)
        || (branch_cond_field != `SMX_SB_NEVER
            && sb_cond == test_sense);

    // status update source: micro flags bypass when ms is the source
    wire [3:0] stu_src = a_src_is_ms ? micro_status_reg
                                     : a_operand_path[3:0];
    logic [3:0] stu_new;
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            stu_new[i] = upd_bit(emu_entry[2*i +: 2],
                                 macro_status[i], stu_src[i]);
        end
    end

    // conditional memory access
    wire [W-1:0] acc_opnd = is_cmb ? b_operand_path
                                   : a_operand_path;
    wire         acc_start = is_acc && !mem_req;

    // wishbone decode
    wire wb_hit = wb_cyc_i && wb_stb_i && !wb_ack_o;
    wire wb_wr  = wb_hit && wb_we_i;
    wire et_sel = wb_adr_i >= `SMX_ADR_ET_LO
               && wb_adr_i <= `SMX_ADR_ET_HI;
    wire [3:0] et_idx = wb_adr_i[5:2];
    logic [31:0] rd_mux;
    always_comb begin
        rd_mux = 32'h0;
        if (et_sel) begin
            rd_mux = {22'h0, emu_table[et_idx]};
        end else begin
            unique case (wb_adr_i)
                `SMX_ADR_STATUS: rd_mux = {16'h0, macro_status};
                `SMX_ADR_XR:     rd_mux = {16'h0, extension_reg};
                `SMX_ADR_RR:     rd_mux = {16'h0, read_return_reg};
                `SMX_ADR_LC:     rd_mux = {27'h0, link, loop_counter};
                default:         rd_mux = 32'h0;
            endcase
        end
    end

    // bus slave: one wait state, unmapped reads zero
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0;
        end else begin
            wb_ack_o <= wb_hit;
            wb_dat_o <= wb_hit ? rd_mux : 32'h0;
        end
    end

    always_ff @(posedge clk) begin
        if (wb_wr && et_sel && wb_sel_i[0] && wb_sel_i[1]) begin
            emu_table[et_idx] <= wb_dat_i[9:0];
        end
    end

    // macro status: command update wins over a software write
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            macro_status <= 16'h0;
        end else if (is_stu) begin
            macro_status[3:0] <= stu_new;
        end else if (wb_wr && wb_adr_i == `SMX_ADR_STATUS) begin
            if (wb_sel_i[0]) macro_status[7:0] <= wb_dat_i[7:0];
            if (wb_sel_i[1]) macro_status[15:8] <= wb_dat_i[15:8];
        end
    end

    // loop counter, link and extension register
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            loop_counter <= `SMX_LC_RESET;
            link         <= 1'b0;
            extension_reg <= '0;
        end else begin
            if (lc_load) begin
                loop_counter <= lc_value;
            end else if (is_div && !lc_zero) begin
                loop_counter <= loop_counter - 4'h1;
            end
            // divide update wins over a same-cycle clear
            if (is_div && cin_one) begin
                link <= div_carry;
            end else if (link_clear) begin
                link <= 1'b0;
            end
            if (xr_load) begin
                extension_reg <= xr_value;
            end else if (dl_shift) begin
                extension_reg <= {extension_reg[W-2:0], link};
            end
        end
    end

    // results to sequencer
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            dest_data     <= '0;
            dest_we       <= 1'b0;
            main_bus_path <= '0;
            branch_take   <= 1'b0;
            branch_addr   <= 10'h0;
            inhibit_next  <= 1'b0;
            fn_mem_go     <= 1'b0;
        end else begin
            dest_we     <= is_div || is_btb || is_stu || is_acc
                        || dl_shift;
            branch_addr <= branch_target_field;
            fn_mem_go   <= fn_mem_req && !is_acc;
            if (is_div) begin
                dest_data     <= div_res;
                main_bus_path <= div_res;
                branch_take   <= lc_zero;
                inhibit_next  <= lc_zero
                    && next_ctrl_field == `SMX_NX_INHIBIT;
            end else if (dl_shift) begin
                dest_data     <= {a_operand_path[W-2:0],
                                  extension_reg[W-1]};
                main_bus_path <= {a_operand_path[W-2:0],
                                  extension_reg[W-1]};
                branch_take   <= 1'b0;
                inhibit_next  <= 1'b0;
            end else begin
                dest_data     <= a_operand_path;
                main_bus_path <= a_operand_path;
                branch_take   <= is_btb && btb_hit;
                inhibit_next  <= is_btb && btb_hit
                    && next_ctrl_field == `SMX_NX_INHIBIT;
            end
        end
    end

    // conditional memory access: request held until acknowledge
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            mem_req   <= 1'b0;
            mem_rmw   <= 1'b0;
            mem_byte  <= 1'b0;
            mem_addr  <= '0;
            mem_wdata <= '0;
            read_return_reg <= '0;
        end else begin
            if (acc_start) begin
                mem_req   <= 1'b1;
                mem_rmw   <= emu_entry[`SMX_ET_RMW];
                mem_byte  <= emu_entry[`SMX_ET_BYTE];
                mem_addr  <= acc_opnd;
                mem_wdata <= acc_opnd;
            end else if (mem_req && mem_ack) begin
                mem_req <= 1'b0;
            end
            if (mem_req && mem_ack) begin
                read_return_reg <= mem_byte
                    ? {{(W-8){1'b0}}, mem_rdata[7:0]}
                    : mem_rdata;
            end
        end
    end
endmodule

// *** tb/smx_exec_properties.sv ***
// Purpose: port properties of the special microcommand block
// Assumes: one clock domain, async active-low reset
// Notes:   emulate table effects are judged by the bench
`include "smx_consts.svh"
module smx_exec_properties #(
    parameter int W = 16
) (
    input wire logic         clk, arst_n, cmd_valid, test_sense,
    input wire logic         flag_carry, flag_overflow, flag_zero,
    input wire logic         flag_negative, flag_positive, flag_odd,
    input wire logic         mem_req, mem_ack, mem_byte, link,
    input wire logic         branch_take, inhibit_next, fn_mem_go,
    input wire logic [4:0]   command_code_field,
    input wire logic [3:0]   carry_mode_field, bit_select, loop_counter,
    input wire logic [2:0]   branch_cond_field,
    input wire logic [1:0]   next_ctrl_field,
    input wire logic [9:0]   branch_target_field, branch_addr,
    input wire logic [W-1:0] a_operand_path, b_operand_path, dest_data,
    input wire logic [W-1:0] mem_addr, mem_rdata, read_return_reg
);
    wire logic [W:0]   sum = {1'b0, a_operand_path}
                           + {1'b0, ~b_operand_path} + 1'b1;
    wire logic         div_c = sum[W];
    wire logic [W-1:0] div_r = div_c ? sum[W-1:0] : a_operand_path;
    wire logic [4:0]   op = command_code_field;
    wire logic         is_div = cmd_valid && op == `SMX_OP_DIV;
    wire logic         is_btb = cmd_valid && op == `SMX_OP_BTB;
    wire logic         is_acc = cmd_valid
                           && (op == `SMX_OP_CMA || op == `SMX_OP_CMB);
    wire logic [7:0]   cvec = {1'b0, flag_odd, flag_positive,
                           flag_negative, flag_zero, flag_overflow,
                           flag_carry, loop_counter == 4'h0};
    wire logic         cond_ok = branch_cond_field != `SMX_SB_NEVER
                           && cvec[branch_cond_field] == test_sense;
    wire logic         btb_exp = cond_ok
                           || a_operand_path[bit_select] == test_sense;
    wire logic [W-1:0] acc_adr = op == `SMX_OP_CMB ? b_operand_path
                           : a_operand_path;
    wire logic [W-1:0] rr_exp = mem_byte ? {8'h00, mem_rdata[7:0]}
                           : mem_rdata;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);
    chk_div_result: assert property (
        is_div |=> dest_data == $past(div_r)) else $error("divide result");
    chk_div_exit: assert property (
        is_div && loop_counter == 4'h0 |=> branch_take
        && loop_counter == 4'h0) else $error("divide exit");
    chk_div_link: assert property (
        is_div && carry_mode_field == `SMX_MC_DIV |=> link == $past(div_c))
        else $error("divide link");
    chk_div_no_inhibit: assert property (
        is_div && next_ctrl_field != `SMX_NX_INHIBIT |=> !inhibit_next)
        else $error("divide inhibit");
    chk_btb_pass: assert property (
        is_btb |=> dest_data == $past(a_operand_path)
        && branch_addr == $past(branch_target_field)) else $error("btb pass");
    chk_btb_take: assert property (
        is_btb |=> branch_take == $past(btb_exp)) else $error("btb take");
    chk_acc_addr: assert property (
        is_acc && !mem_req |=> mem_req && mem_addr == $past(acc_adr))
        else $error("access address");
    chk_rr_load: assert property (
        mem_req && mem_ack |=> read_return_reg == $past(rr_exp))
        else $error("return register");
    chk_fn_override: assert property (
        is_acc |=> !fn_mem_go) else $error("function access not overridden");
endmodule
bind smx_exec smx_exec_properties #(.W(W)) u_props (.*);

// *** tb/smx_mem_model.sv ***
// Purpose: memory bus responder for conditional operand accesses
// Assumes: one request, held until acknowledged
// Notes:   read data is the inverted address
module smx_mem_model #(
    parameter int DLY = 2
) (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        arst_n,
    // request
    input  wire logic        mem_req,
    input  wire logic [15:0] mem_addr,
    // answer
    output logic             mem_ack,
    output logic [15:0]      mem_rdata
);
    int cnt;
    wire logic go = mem_req && !mem_ack && cnt == DLY;
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cnt <= 0;
            mem_ack <= 1'b0;
            mem_rdata <= 16'h0000;
        end else begin
            mem_ack <= go;
            // stale data flips so a late capture never matches
            mem_rdata <= go ? ~mem_addr : ~mem_rdata;
            cnt <= (mem_req && !mem_ack && !go) ? cnt + 1 : 0;
        end
    end
endmodule

// *** tb/smx_exec_tb_top.sv ***
// Purpose: self-checking bench for the special microcommand block
// Assumes: memory model answers after a fixed delay
// Notes:   loop counter is zero during the bit-test sweep
`include "smx_consts.svh"
module smx_exec_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0, arst_n = 1'b0, cmd_valid = 1'b0, skip_select = 1'b0;
    logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, dl_shift = 1'b0;
    logic test_sense = 1'b0, a_src_is_ms = 1'b0, fn_mem_req = 1'b0;
    logic lc_load = 1'b0, xr_load = 1'b0, link_clear = 1'b0;
    logic flag_carry = 1'b0, flag_overflow = 1'b0, flag_zero = 1'b0;
    logic flag_negative = 1'b0, flag_positive = 1'b0, flag_odd = 1'b0;
    logic [7:0]  wb_adr_i = 8'h00;
    logic [3:0]  wb_sel_i = 4'hf, bit_select = 4'h0, carry_mode_field = 4'h0;
    logic [3:0]  lc_value = 4'h0, micro_status_reg = 4'h0;
    logic [31:0] wb_dat_i = 32'h0;
    logic [4:0]  command_code_field = 5'h00;
    logic [2:0]  branch_cond_field = 3'h0;
    logic [1:0]  next_ctrl_field = 2'h0;
    logic [9:0]  branch_target_field = 10'h000;
    logic [15:0] xr_value = 16'h0, a_operand_path = 16'h0;
    logic [15:0] b_operand_path = 16'h0, emulated_instr_hold = 16'h0;
    logic [31:0] wb_dat_o;
    logic [15:0] dest_data, main_bus_path, mem_addr, mem_wdata, mem_rdata;
    logic [15:0] macro_status, extension_reg, read_return_reg;
    logic [9:0]  branch_addr;
    logic [3:0]  loop_counter;
    logic        wb_ack_o, dest_we, branch_take, inhibit_next, fn_mem_go;
    logic        mem_req, mem_rmw, mem_byte, mem_ack, link;
    int          bad_count = 0, check_count = 0;
    smx_exec #(.W(16)) u_dut (.*);
    smx_mem_model #(.DLY(2)) u_mem (.clk(clk), .arst_n(arst_n),
        .mem_req(mem_req), .mem_addr(mem_addr), .mem_ack(mem_ack),
        .mem_rdata(mem_rdata));
    always #10 clk = ~clk;
    task automatic chk(input logic [31:0] got, exp);
        check_count++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic results();
        if (bad_count == 0 && check_count > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic hang();
        bad_count++;
        results();
    endtask
    task automatic wb(input logic we, input logic [7:0] adr,
                      input logic [31:0] d, output logic [31:0] q);
        int n;
        @(posedge clk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_dat_i <= d;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 20);
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        if (wb_ack_o !== 1'b1) hang();
    endtask
    task automatic cmd(input logic [4:0] op, input logic [15:0] a, b);
        @(posedge clk);
        cmd_valid <= 1'b1;
        command_code_field <= op;
        a_operand_path <= a;
        b_operand_path <= b;
        @(posedge clk);
        cmd_valid <= 1'b0;
        #1;
    endtask
    task automatic t_divide();
        @(posedge clk);
        lc_load <= 1'b1;
        xr_load <= 1'b1;
        lc_value <= 4'h1;
        xr_value <= 16'h00f0;
        carry_mode_field <= `SMX_MC_DIV;
        next_ctrl_field <= 2'h1;
        @(posedge clk);
        lc_load <= 1'b0;
        xr_load <= 1'b0;
        cmd(`SMX_OP_DIV, 16'h0008, 16'h0005);
        chk(dest_data, 16'h0003);
        chk(link, 1'b1);
        chk({loop_counter, branch_take}, 5'h00);
        @(posedge clk);
        dl_shift <= 1'b1;
        @(posedge clk);
        dl_shift <= 1'b0;
        #1;
        chk({dest_data, extension_reg}, 32'h001001e1);
        cmd(`SMX_OP_DIV, 16'h0003, 16'h0005);
        chk({dest_data, link}, 17'h00006);
        chk({branch_take, inhibit_next, loop_counter}, 6'h20);
        @(posedge clk);
        next_ctrl_field <= `SMX_NX_INHIBIT;
        cmd(`SMX_OP_DIV, 16'h0003, 16'h0005);
        chk({branch_take, inhibit_next}, 2'h3);
        // closing shift after the exit iteration
        @(posedge clk);
        dl_shift <= 1'b1;
        @(posedge clk);
        dl_shift <= 1'b0;
        #1;
        chk({dest_we, link, extension_reg}, 18'h203c2);
        chk(dest_data, 16'h0006);
    endtask
    task automatic t_bittest();
        logic s;
        logic [2:0] c;
        skip_select <= 1'b1;
        bit_select <= 4'h9;
        for (int i = 0; i < 16; i++) begin
            @(posedge clk);
            s = i[3];
            c = i[2:0];
            test_sense <= s;
            branch_cond_field <= c;
            {flag_carry, flag_overflow, flag_zero} <= {3{s}};
            {flag_negative, flag_positive, flag_odd} <= {3{s}};
            branch_target_field <= {i[3:0], 6'h15};
            cmd(`SMX_OP_BTB, s ? 16'h0000 : 16'hffff, 16'h0000);
            chk({branch_take, branch_addr},
                {c != 3'h7 && (c != 3'h0 || s), i[3:0], 6'h15});
            chk(dest_data, s ? 16'h0000 : 16'hffff);
            chk({dest_we, main_bus_path},
                {1'b1, s ? 16'h0000 : 16'hffff});
        end
        @(posedge clk);
        branch_cond_field <= `SMX_SB_NEVER;
        cmd(`SMX_OP_BTB, 16'h0200, 16'h0000);
        chk(branch_take, 1'b1);
    endtask
    task automatic t_status();
        logic [31:0] q;
        wb(1'b1, `SMX_ADR_ET_LO + 8'h0c, 32'h000000e4, q);
        wb(1'b1, `SMX_ADR_ET_LO + 8'h10, 32'h000000ff, q);
        wb(1'b1, `SMX_ADR_STATUS, 32'h00000003, q);
        emulated_instr_hold <= 16'h3000;
        cmd(`SMX_OP_STU, 16'h0008, 16'h0000);
        chk({macro_status, dest_data}, 32'h000d0008);
        @(posedge clk);
        emulated_instr_hold <= 16'h4000;
        a_src_is_ms <= 1'b1;
        micro_status_reg <= 4'h6;
        cmd(`SMX_OP_STU, 16'h0001, 16'h0000);
        chk(macro_status, 16'h0006);
        wb(1'b0, `SMX_ADR_STATUS, 32'h0, q);
        chk(q, 32'h00000006);
        wb(1'b0, 8'h20, 32'h0, q);
        chk(q, 32'h0);
    endtask
    task automatic t_access(input logic [4:0] op, input logic [3:0] idx,
                            input logic [9:0] ent, input logic [15:0] adr);
        logic [31:0] q;
        logic [15:0] e;
        int n;
        e = op == `SMX_OP_CMB ? ~adr : adr;
        wb(1'b1, `SMX_ADR_ET_LO + {2'h0, idx, 2'h0}, {22'h0, ent}, q);
        emulated_instr_hold <= {idx, 12'h000};
        fn_mem_req <= 1'b1;
        cmd(op, adr, ~adr);
        chk({mem_req, mem_rmw, mem_byte, fn_mem_go},
            {1'b1, ent[8], ent[9], 1'b0});
        chk({mem_addr, mem_wdata}, {e, e});
        chk({dest_we, main_bus_path}, {1'b1, adr});
        chk(dest_data, adr);
        @(posedge clk);
        fn_mem_req <= 1'b0;
        n = 0;
        while (mem_req !== 1'b0 && n < 50) begin
            @(posedge clk);
            n++;
        end
        if (mem_req !== 1'b0) hang();
        wb(1'b0, `SMX_ADR_RR, 32'h0, q);
        chk(q, ent[9] ? {24'h0, ~e[7:0]} : {16'h0, ~e});
    endtask
    initial begin
        repeat (16) @(posedge clk);
        arst_n <= 1'b1;
        #1;
        chk({loop_counter, link, macro_status}, 21'h1e0000);
        t_divide();
        t_bittest();
        t_status();
        t_access(`SMX_OP_CMA, 4'h5, 10'h300, 16'h1234);
        t_access(`SMX_OP_CMB, 4'h6, 10'h000, 16'h0f0f);
        results();
    end
endmodule
